// File: tbrg_defines.vh
// Overview of operation
// R1 - control bits pick reload, capture, baud, off
// R2 - tx clock from other timer or overflows
// R3 - rx clock steered likewise, independently
// R4 - baud rollover reloads count from reload pair
// R5 - serial bit rate is overflow rate / 16
// R6 - increment osc/2 in baud, osc/12 otherwise
// R7 - rate = osc / (32 x (65536 - reload))
// R8 - baud rollover sets no overflow flag, no interrupt
// R9 - baud trigger edge sets flag, no reload
// R10 - software avoids count bytes during baud mode
// R11 - software reads, not writes, reload in baud
// R12 - software stops timer before register access
// R13 - timer setup control values per mode
// R14 - counter setup control values per mode
// R15 - trigger edge reloads or captures unless baud; the code skips the reload while dcen_reg is set
// R16 - select counts internal clock or count pin
// R17 - edge flag shares overflow interrupt request
// R18 - pins synchronised, falling edges detected
`ifndef TBRG_DEFINES_VH
`define TBRG_DEFINES_VH
// ====================================================
// register byte addresses
`define TBRG_ADDR_CTRL 4'h0
`define TBRG_ADDR_RELOAD 4'h4
`define TBRG_ADDR_COUNT 4'h8
`define TBRG_ADDR_MODE 4'hc
// ====================================================
// control register fields
`define TBRG_B_CPRL 0
`define TBRG_B_CT 1
`define TBRG_B_RUN 2
`define TBRG_B_EXEN 3
`define TBRG_B_TX_CLOCK_SELECT 4
`define TBRG_B_RCLK 5
`define TBRG_B_EXF 6
`define TBRG_B_TF 7
`define TBRG_CTRL_RESET 8'h00
`define TBRG_COUNT_RESET 16'h0000
// ====================================================
// prescale and bit divide
`define TBRG_STATE_DIV 4'h2
`define TBRG_MACHINE_DIV 4'hc
`define TBRG_BIT_DIV 4'hf
// ====================================================
// axi responses
`define TBRG_RESP_OKAY 2'b00
`define TBRG_RESP_SLVERR 2'b10
`endif

// File: tbrg_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "tbrg_defines.vh"
module tbrg_timer #(
  parameter CW = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire count_input_pin,
  input wire trigger_pin,
  input wire other_timer_tick,
  output reg tx_bit_tick,
  output reg rx_bit_tick,
  output reg timer_irq
);
  // ====================================================
  // registers
  reg [7:0] ctrl_reg;
  reg dcen_reg;
  reg [CW-1:0] reload_reg;
  reg [CW-1:0] count_reg;
  reg [3:0] pre_reg;
  reg [3:0] txdiv_reg;
  reg [3:0] rxdiv_reg;
  reg [2:0] cnt_sync_reg;
  reg [2:0] trg_sync_reg;
  reg [31:0] wdata_reg;
  reg [3:0] awaddr_reg;
  reg aw_have_reg;
  reg w_have_reg;

  wire timer_run = ctrl_reg[`TBRG_B_RUN];
  wire ext_trigger_enable = ctrl_reg[`TBRG_B_EXEN];
  wire tx_clock_select = ctrl_reg[`TBRG_B_TX_CLOCK_SELECT];
  wire rx_clock_select = ctrl_reg[`TBRG_B_RCLK];
  wire capture_reload_select = ctrl_reg[`TBRG_B_CPRL];
  wire timer_counter_select = ctrl_reg[`TBRG_B_CT];
  wire baud_mode = tx_clock_select | rx_clock_select; // R1

  // ====================================================
  // pin synchronisers and falling edges
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_sync_reg <= 3'h7;
      trg_sync_reg <= 3'h7;
    end else begin
      cnt_sync_reg <= {cnt_sync_reg[1:0], count_input_pin}; // R18
      trg_sync_reg <= {trg_sync_reg[1:0], trigger_pin}; // R18
    end
  end
  // edge detect reads only stages 1 and 2, never stage 0
  wire cnt_fall = cnt_sync_reg[2] & ~cnt_sync_reg[1];
  wire trg_fall = trg_sync_reg[2] & ~trg_sync_reg[1];
  wire trg_level = trg_sync_reg[1];

  // ====================================================
  // prescaler: aclk stands in for the oscillator
  wire [3:0] pre_div = baud_mode ? `TBRG_STATE_DIV : `TBRG_MACHINE_DIV; // R6
  wire pre_tick = (pre_reg >= pre_div - 4'h1);
  always @(posedge aclk) begin
    if (!aresetn || !timer_run)
      pre_reg <= 4'h0;
    else if (pre_tick)
      pre_reg <= 4'h0;
    else
      pre_reg <= pre_reg + 4'h1;
  end
  wire inc = timer_run & (timer_counter_select ? cnt_fall : pre_tick); // R16 R1
  wire down = dcen_reg & ~trg_level & ~baud_mode & ~capture_reload_select;
  wire at_top = (count_reg == {CW{1'b1}});
  wire under = down & (count_reg == reload_reg);
  wire roll = inc & (down ? under : at_top);
  wire ext_evt = ext_trigger_enable & trg_fall;

  // ====================================================
  // axi write channel
  reg [3:0] wstrb_reg;
  wire wstrb_r0 = wstrb_reg[0];
  wire do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire wr_ctrl = do_write && awaddr_reg == `TBRG_ADDR_CTRL && wstrb_r0;
  wire wr_rel = do_write && awaddr_reg == `TBRG_ADDR_RELOAD;
  wire wr_cnt = do_write && awaddr_reg == `TBRG_ADDR_COUNT;
  wire wr_mode = do_write && awaddr_reg == `TBRG_ADDR_MODE && wstrb_r0;

  function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] nw;
    input en;
    begin
      merge_byte = en ? nw : old;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TBRG_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg[1:0] != 2'b00) ? `TBRG_RESP_SLVERR : `TBRG_RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ====================================================
  // control, reload, counter
  // hardware sets of the flags win over a software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `TBRG_CTRL_RESET;
      dcen_reg <= 1'b0;
      reload_reg <= `TBRG_COUNT_RESET;
      count_reg <= `TBRG_COUNT_RESET;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= wdata_reg[7:0];
      if (wr_mode)
        dcen_reg <= wdata_reg[0];
      // software writes reload while running in baud mode at its own risk
      if (wr_rel) begin // R11 R12
        reload_reg[7:0] <= merge_byte(reload_reg[7:0], wdata_reg[7:0], wstrb_reg[0]);
        reload_reg[15:8] <= merge_byte(reload_reg[15:8], wdata_reg[15:8], wstrb_reg[1]);
      end
      if (roll && !baud_mode)
        ctrl_reg[`TBRG_B_TF] <= 1'b1; // R8
      if (ext_evt)
        ctrl_reg[`TBRG_B_EXF] <= 1'b1; // R9 R17
      else if (roll && dcen_reg && !baud_mode && !capture_reload_select)
        ctrl_reg[`TBRG_B_EXF] <= ~ctrl_reg[`TBRG_B_EXF];
      if (wr_cnt) begin // R10
        count_reg[7:0] <= merge_byte(count_reg[7:0], wdata_reg[7:0], wstrb_reg[0]);
        count_reg[15:8] <= merge_byte(count_reg[15:8], wdata_reg[15:8], wstrb_reg[1]);
      end else if (roll && under)
        count_reg <= {CW{1'b1}};
      else if (roll && (baud_mode || !capture_reload_select))
        count_reg <= reload_reg; // R4 R7
      else if (!baud_mode && !capture_reload_select && ext_evt && !down)
        count_reg <= reload_reg; // R15
      else if (inc)
        count_reg <= down ? count_reg - 16'h0001 : count_reg + 16'h0001;
      if (!baud_mode && capture_reload_select && ext_evt && !wr_rel)
        reload_reg <= count_reg; // R15
    end
  end

  // ====================================================
  // serial bit clocks: one pulse per sixteen source pulses, overflows or other timer ticks
  wire tx_src = tx_clock_select ? (roll & baud_mode) : other_timer_tick; // R2
  wire rx_src = rx_clock_select ? (roll & baud_mode) : other_timer_tick; // R3
  always @(posedge aclk) begin
    if (!aresetn) begin
      txdiv_reg <= 4'h0;
      rxdiv_reg <= 4'h0;
      tx_bit_tick <= 1'b0;
      rx_bit_tick <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      if (tx_src)
        txdiv_reg <= txdiv_reg + 4'h1; // R5
      if (rx_src)
        rxdiv_reg <= rxdiv_reg + 4'h1; // R5
      tx_bit_tick <= tx_src && txdiv_reg == `TBRG_BIT_DIV; // R5
      rx_bit_tick <= rx_src && rxdiv_reg == `TBRG_BIT_DIV; // R5
      timer_irq <= ctrl_reg[`TBRG_B_TF] | ctrl_reg[`TBRG_B_EXF]; // R17
    end
  end

  // ====================================================
  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TBRG_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TBRG_RESP_OKAY;
        case (s_axi_araddr)
          `TBRG_ADDR_CTRL: s_axi_rdata <= {24'h0, ctrl_reg};
          `TBRG_ADDR_RELOAD: s_axi_rdata <= {16'h0, reload_reg};
          `TBRG_ADDR_COUNT: s_axi_rdata <= {16'h0, count_reg};
          `TBRG_ADDR_MODE: s_axi_rdata <= {31'h0, dcen_reg};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TBRG_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tbrg_serial_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// serial port side: other timer pulses, bit tick counts
module tbrg_serial_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_bit_tick,
  input wire logic rx_bit_tick,
  output var logic other_timer_tick,
  output var int tx_seen,
  output var int rx_seen
);
  logic [2:0] div_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 3'h0;
      other_timer_tick <= 1'b0;
      tx_seen <= 0;
      rx_seen <= 0;
    end else begin
      div_reg <= (div_reg == 3'h4) ? 3'h0 : div_reg + 3'h1;
      // one pulse every 5 cycles, a rate the timer never gives
      other_timer_tick <= (div_reg == 3'h4);
      tx_seen <= tx_seen + int'(tx_bit_tick);
      rx_seen <= rx_seen + int'(rx_bit_tick);
    end
  end
endmodule
`default_nettype wire

// File: tbrg_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// handshake and bit tick checks
module tbrg_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_bit_tick,
  input wire logic rx_bit_tick,
  input wire logic timer_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid) else $error("bvalid late");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
  a_tx_spacing: assert property (tx_bit_tick |=> !tx_bit_tick [*8]) else $error("tx ticks too close");
  a_rx_spacing: assert property (rx_bit_tick |=> !rx_bit_tick [*8]) else $error("rx ticks too close");
  a_reset_quiet: assert property ($rose(aresetn) |-> !timer_irq && !tx_bit_tick) else $error("busy after reset");
endmodule
bind tbrg_timer tbrg_checker tbrg_checker_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .tx_bit_tick, .rx_bit_tick, .timer_irq);
`default_nettype wire

// File: test_timer_baud_rate_generator.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbrg_defines.vh"
module test_timer_baud_rate_generator;
  logic aclk = 0, aresetn = 0, trigger_pin = 1, count_input_pin = 1;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, rv;
  logic [1:0] rr;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire other_timer_tick, tx_bit_tick, rx_bit_tick, timer_irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int tx_seen, rx_seen, t0, r0, n_errors = 0, cmp_count = 0;
  always #12.5 aclk = ~aclk;
  tbrg_timer tbrg_timer_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin,
    .trigger_pin, .other_timer_tick, .tx_bit_tick, .rx_bit_tick, .timer_irq);
  tbrg_serial_model tbrg_serial_model_inst (.aclk, .aresetn, .tx_bit_tick, .rx_bit_tick, .other_timer_tick,
    .tx_seen, .rx_seen);
  // ==========
  // shared tasks
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string what, input logic [31:0] got, lo, hi);
    begin
      cmp_count++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
        n_errors++;
        $display("BAD %s expected %0h..%0h seen %0h", what, lo, hi, got);
      end
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40 && !(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid); i++) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      rr = s_axi_bresp;
      if (i == 40) begin
        n_errors++;
        close_out();
      end
    end
  endtask
  task rd(input logic [3:0] a);
    int i;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      if (i == 40) begin
        n_errors++;
        close_out();
      end
    end
  endtask
  task pulse(input logic trg);
    begin
      @(posedge aclk);
      if (trg) trigger_pin <= 1'b0;
      else count_input_pin <= 1'b0;
      repeat (6) @(posedge aclk);
      trigger_pin <= 1'b1;
      count_input_pin <= 1'b1;
      repeat (6) @(posedge aclk);
    end
  endtask
  task count_ticks(input int n);
    begin
      t0 = tx_seen;
      r0 = rx_seen;
      repeat (n) @(posedge aclk);
    end
  endtask
  // ==========
  // scenarios
  task t_baud;
    begin
      wr(`TBRG_ADDR_RELOAD, 32'h0000ffff);
      // count starts at the top so the first rollover comes at once
      wr(`TBRG_ADDR_COUNT, 32'h0000ffff);
      wr(`TBRG_ADDR_CTRL, 32'h00000034);
      count_ticks(320);
      chk("tx ticks", tx_seen - t0, 9, 11);
      chk("rx ticks", rx_seen - r0, 9, 11);
      rd(`TBRG_ADDR_CTRL);
      chk("ctrl flags", rv[7:0], 8'h34, 8'h34);
      chk("irq", timer_irq, 0, 0);
      rd(`TBRG_ADDR_RELOAD);
      chk("reload kept", rv, 32'hffff, 32'hffff);
      $display("t_baud done");
    end
  endtask
  task t_split;
    begin
      wr(`TBRG_ADDR_CTRL, 32'h00000000);
      chk("bresp", rr, `TBRG_RESP_OKAY, `TBRG_RESP_OKAY);
      wr(`TBRG_ADDR_RELOAD, 32'h0000fffe);
      wr(`TBRG_ADDR_CTRL, 32'h00000024);
      count_ticks(640);
      chk("rx from timer", rx_seen - r0, 9, 11);
      chk("tx from other", tx_seen - t0, 7, 9);
      $display("t_split done");
    end
  endtask
  task t_trigger;
    begin
      wr(`TBRG_ADDR_CTRL, 32'h0000003c);
      @(posedge aclk);
      trigger_pin <= 1'b0;
      repeat (8) @(posedge aclk);
      trigger_pin <= 1'b1;
      rd(`TBRG_ADDR_CTRL);
      chk("edge flag", rv[7:0], 8'h7c, 8'h7c);
      chk("irq", timer_irq, 1, 1);
      rd(4'h2);
      chk("misaligned resp", rr, `TBRG_RESP_SLVERR, `TBRG_RESP_SLVERR);
      $display("t_trigger done");
    end
  endtask
  task t_counter;
    begin
      wr(`TBRG_ADDR_CTRL, 32'h00000000);
      wr(`TBRG_ADDR_COUNT, 32'h0000fffe);
      wr(`TBRG_ADDR_RELOAD, 32'h00001234);
      wr(`TBRG_ADDR_CTRL, 32'h00000002);
      wr(`TBRG_ADDR_CTRL, 32'h00000006);
      repeat (3) pulse(1'b0);
      rd(`TBRG_ADDR_COUNT);
      chk("count after roll", rv, 32'h1235, 32'h1235);
      rd(`TBRG_ADDR_CTRL);
      chk("overflow flag", rv[7:0], 8'h86, 8'h86);
      chk("irq", timer_irq, 1, 1);
      wr(`TBRG_ADDR_CTRL, 32'h0000000e);
      pulse(1'b1);
      rd(`TBRG_ADDR_COUNT);
      chk("trigger reload", rv, 32'h1234, 32'h1234);
      rd(`TBRG_ADDR_CTRL);
      chk("reload flags", rv[7:0], 8'h4e, 8'h4e);
      wr(`TBRG_ADDR_CTRL, 32'h00000000);
      wr(`TBRG_ADDR_COUNT, 32'h00000055);
      wr(`TBRG_ADDR_CTRL, 32'h0000000b);
      wr(`TBRG_ADDR_CTRL, 32'h0000000f);
      pulse(1'b1);
      rd(`TBRG_ADDR_RELOAD);
      chk("capture", rv, 32'h55, 32'h55);
      rd(`TBRG_ADDR_CTRL);
      chk("capture flags", rv[7:0], 8'h4f, 8'h4f);
      $display("t_counter done");
    end
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TBRG_ADDR_CTRL);
    chk("ctrl reset", rv, 0, 0);
    t_baud();
    t_split();
    t_trigger();
    t_counter();
    close_out();
  end
endmodule
`default_nettype wire
